//--- hdl/ohc_pkg.sv
// Constants, encodings and types for the OTP/ECC-aware NAND host controller.
// Assumes a 100 MHz ref_clk and an 8-bit asynchronous NAND die on the pins.
package ohc_pkg;

	// ------------------------------------------------------------
	// Clock and pin timing
	// ------------------------------------------------------------
	localparam int CLK_MHZ         = 100;
	localparam int PHASE_NS        = 20;   // One strobe phase
	localparam int PHASE_CYC       = (PHASE_NS * CLK_MHZ + 999) / 1000;
	localparam int SETTLE_NS       = 200;  // Let ready/busy fall before polling
	localparam int SETTLE_CYC      = (SETTLE_NS * CLK_MHZ + 999) / 1000;

	// ------------------------------------------------------------
	// Register map (byte offsets on APB)
	// ------------------------------------------------------------
	localparam logic [7:0] REG_CTRL    = 8'h00;
	localparam logic [7:0] REG_ADDR    = 8'h04;
	localparam logic [7:0] REG_DATA    = 8'h08;
	localparam logic [7:0] REG_STATUS  = 8'h0c;
	localparam logic [7:0] REG_CONFIG  = 8'h10;

	// CTRL fields
	localparam int CTRL_OP_LSB   = 0;
	localparam int CTRL_P1_LSB   = 8;
	// STATUS fields
	localparam int ST_BUSY_BIT   = 0;
	localparam int ST_FAIL_BIT   = 1;
	localparam int ST_PROT_BIT   = 2;
	localparam int ST_REFUSE_BIT = 3;
	localparam int ST_BAD_BIT    = 4;
	localparam int ST_RB_BIT     = 5;
	localparam int ST_MODE_LSB   = 6;
	localparam int ST_BYTE_LSB   = 8;
	localparam int ST_PCNT_LSB   = 16;
	localparam int ST_ECC_LSB    = 20;
	// CONFIG fields
	localparam int CFG_ECC_BIT   = 0;
	localparam int CFG_WEAR_BIT  = 1;
	localparam logic [31:0] CFG_RESET = 32'h0000_0000;

	// ------------------------------------------------------------
	// NAND command and feature values
	// ------------------------------------------------------------
	localparam logic [7:0] CMD_READ       = 8'h00;
	localparam logic [7:0] CMD_READ_GO    = 8'h30;
	localparam logic [7:0] CMD_COL_OUT    = 8'h05;
	localparam logic [7:0] CMD_COL_OUT_GO = 8'he0;
	localparam logic [7:0] CMD_PROG       = 8'h80;
	localparam logic [7:0] CMD_PROG_GO    = 8'h10;
	localparam logic [7:0] CMD_STATUS     = 8'h70;
	localparam logic [7:0] CMD_SET_FEAT   = 8'hef;
	localparam logic [7:0] FEAT_OTP       = 8'h90;
	localparam logic [7:0] P1_NORMAL      = 8'h00;
	localparam logic [7:0] P1_OTP_OPER    = 8'h01;
	localparam logic [7:0] P1_OTP_PROTECT = 8'h03;
	localparam logic [7:0] ZERO_BYTE      = 8'h00;
	localparam int STS_FAIL_BIT = 0;
	localparam int STS_RDY_BIT  = 5;

	// OTP page window and bad-block mark
	localparam logic [15:0] OTP_PAGE_LO   = 16'h0002;
	localparam logic [15:0] OTP_PAGE_HI   = 16'h001f;
	localparam logic [15:0] SPARE_COL     = 16'd2048;
	localparam logic [7:0]  BAD_MARK      = 8'h00;

	// Internal ECC layout and limits
	localparam logic [3:0]  PARITY_LO     = 4'h8;  // Parity at 8..F per group
	localparam int          MAX_PARTIALS  = 4;
	localparam logic [3:0]  ECC_BITS_STD  = 4'd4;  // Per 528 bytes
	localparam logic [3:0]  ECC_BITS_BLK0 = 4'd1;  // Block 0, under 1000 cycles
	localparam logic [3:0]  ECC_BITS_INT  = 4'd0;  // Die corrects itself

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef enum logic [3:0] {
		OP_NONE    = 4'b0000,
		OP_FEATURE = 4'b0001,
		OP_PROTECT = 4'b0010,
		OP_PROGRAM = 4'b0011,
		OP_READ    = 4'b0100,
		OP_COLOUT  = 4'b0101,
		OP_RDBYTE  = 4'b0110,
		OP_STATUS  = 4'b0111
	} ohc_op_type;

	typedef enum logic [2:0] {
		K_CMD  = 3'b000,
		K_ADR  = 3'b001,
		K_WR   = 3'b010,
		K_RD   = 3'b011,
		K_WAIT = 3'b100,
		K_END  = 3'b101
	} ohc_kind_type;

	typedef enum logic [1:0] {
		MODE_NORMAL  = 2'b00,
		MODE_OTP     = 2'b01,
		MODE_PROTECT = 2'b11
	} ohc_mode_type;

	typedef enum logic [2:0] {
		S_IDLE   = 3'b000,
		S_ISSUE  = 3'b001,
		S_CYCLE  = 3'b010,
		S_SETTLE = 3'b011,
		S_BUSY   = 3'b100
	} ohc_state_type;

endpackage

//--- hdl/ohc_tick_gen.sv
// Phase enable divider for the NAND pin sequencer.
// Assumes a single free-running ref_clk; emits one-cycle enable pulses.
`timescale 1ns/1ps
module ohc_tick_gen
	import ohc_pkg::*;
(
	input  wire logic ref_clk,
	input  wire logic arst_n,
	output logic      tick
);

	localparam logic [7:0] DIV_LAST = 8'(PHASE_CYC - 1);

	logic [7:0] count;

	// ------------------------------------------------------------
	// Divider
	// ------------------------------------------------------------
	// Free-running so every phase has the same width, at a cost of
	// up to one phase of latency on the first strobe
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			count <= 8'h00;
			tick  <= 1'b0;
		end
		else
		begin
			tick  <= (count == DIV_LAST);
			count <= (count == DIV_LAST) ? 8'h00 : count + 8'h01;
		end
	end

endmodule

//--- hdl/ohc_pin_cycle.sv
// One NAND bus cycle: command, address, data-in or data-out latch.
// Assumes tick is a one-cycle enable; start is honoured only when idle.
`timescale 1ns/1ps
module ohc_pin_cycle
	import ohc_pkg::*;
(
	input  wire logic       ref_clk,
	input  wire logic       arst_n,
	input  wire logic       tick,
	input  wire logic       start,
	input  wire logic [2:0] kind,
	input  wire logic [7:0] wbyte,
	input  wire logic [7:0] ioIn,
	output logic            cle,
	output logic            ale,
	output logic            weN,
	output logic            readStrobeN,
	output logic [7:0]      ioOut,
	output logic            ioOe,
	output logic [7:7]      spare,
	output logic [7:0]      rbyte,
	output logic            done
);

	logic [1:0] phase;
	logic       active;
	logic       isRead;

	assign spare = 1'b0;

	// ------------------------------------------------------------
	// Phase sequencer
	// ------------------------------------------------------------
	// Phase 0 sets up, 1 holds the strobe low, 2 raises it, 3 releases
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			phase       <= 2'd0;
			active      <= 1'b0;
			isRead      <= 1'b0;
			cle         <= 1'b0;
			ale         <= 1'b0;
			weN         <= 1'b1;
			readStrobeN <= 1'b1;
			ioOut       <= 8'h00;
			ioOe        <= 1'b0;
			rbyte       <= 8'h00;
			done        <= 1'b0;
		end
		else
		begin
			done <= 1'b0;
			if (!active && start)
			begin
				active <= 1'b1;
				phase  <= 2'd0;
				isRead <= (kind == K_RD);
				cle    <= (kind == K_CMD);
				ale    <= (kind == K_ADR);
				ioOut  <= wbyte;
				ioOe   <= (kind != K_RD);
			end
			else if (active && tick)
			begin
				phase <= phase + 2'd1;
				unique case (phase)
					2'd0:
					begin
						weN         <= isRead;
						readStrobeN <= !isRead;
					end
					2'd1: ;
					2'd2:
					begin
						// Sample while the die still drives the bus
						if (isRead)
							rbyte <= ioIn;
						weN         <= 1'b1;
						readStrobeN <= 1'b1;
					end
					2'd3:
					begin
						cle    <= 1'b0;
						ale    <= 1'b0;
						ioOe   <= 1'b0;
						active <= 1'b0;
						done   <= 1'b1;
					end
				endcase
			end
		end
	end

endmodule

//--- hdl/ohc_host.sv
// NAND host controller for OTP access, OTP protection and ECC bookkeeping.
// Assumes an APB master on the register side and one 8-bit asynchronous
// NAND die on the pin side; pin inputs are synchronous to ref_clk.
`timescale 1ns/1ps

// What this block does
// - Protect mode entry: set-feature 90h, first parameter 03h, three 00h.
// - In protect mode, program 80h, four 00h addresses, data 00h, 10h.
// - Only read-status 70h queries status in OTP mode; bit 5 mirrors busy.
// - After ready, status bit 0 tells pass or fail of the OTP operation.
// - OTP read: 00h, two column bytes, page 02h-1Fh, two zeros, 30h.
// - Never use cached page read on OTP pages.
// - With internal ECC off, host needs 4 bits per 528 bytes.
// - Block 0 under 1000 cycles needs 1 bit per 528 bytes.
// - After ECC read, status bit 0 flags an uncorrectable error.
// - After status following a read, issue 00h to resume data output.
// - ECC on: one partial program per unit, no parity writes, four max; the block counts programs per page and does not track units.
// - Exit OTP modes: feature 90h, first parameter 00h.
// - OTP operation entry: feature 90h, first parameter 01h, three 00h.
module ohc_host
	import ohc_pkg::*;
(
	input  wire logic        ref_clk,
	input  wire logic        arst_n,
	input  wire logic [7:0]  paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	output logic             chipEnableN,
	output logic             cle,
	output logic             ale,
	output logic             weN,
	output logic             readStrobeN,
	output logic             writeProtectN,
	output logic [7:0]       ioOut,
	output logic             ioOe,
	input  wire logic [7:0]  ioIn,
	input  wire logic        readyBusyN
);

	localparam logic [7:0] SETTLE_LAST = 8'(SETTLE_CYC - 1);

	ohc_state_type state;
	ohc_op_type    op;
	ohc_mode_type  mode;
	logic [3:0]    stepIdx;
	logic [10:0]   step;
	logic [15:0]   col;
	logic [15:0]   row;
	logic [7:0]    p1;
	logic [7:0]    wdata;
	logic [7:0]    dataByte;
	logic [7:0]    statusByte;
	logic [15:0]   curCol;
	logic [15:0]   lastProgRow;
	logic [2:0]    partials;
	logic [7:0]    settle;
	logic          opFail;
	logic          protectedOtp;
	logic          refused;
	logic          badMark;
	logic          eccOn;
	logic          block0LowWear;
	logic          tick;
	logic          cycStart;
	logic          cycDone;
	logic [7:0]    cycByte;
	logic [7:0]    dataByteWire;
	logic [0:0]    unusedSpare;
	logic          apbWrite;
	logic          ctrlWrite;
	logic          accept;
	logic          refuseNow;
	logic [3:0]    minEccBits;
	logic [31:0]   statusWord;
	logic          parityCol;
	logic          samePage;
	logic          otpPageOk;

	// ------------------------------------------------------------
	// Step table
	// ------------------------------------------------------------
	// Each operation is a short list of pin cycles; K_WAIT sleeps on
	// ready/busy and K_END closes the operation
	function automatic logic [10:0] stepOf(
		input ohc_op_type op_i,
		input logic [3:0] i,
		input logic [15:0] c,
		input logic [15:0] r,
		input logic [7:0]  pa,
		input logic [7:0]  wd
	);
		logic [10:0] s;
		s = {K_END, ZERO_BYTE};
		unique case (op_i)
			OP_FEATURE:
				case (i)
					4'd0: s = {K_CMD, CMD_SET_FEAT};
					4'd1: s = {K_ADR, FEAT_OTP};
					4'd2: s = {K_WR, pa};
					4'd3, 4'd4, 4'd5: s = {K_WR, ZERO_BYTE};
					4'd6: s = {K_WAIT, ZERO_BYTE};
					default: s = {K_END, ZERO_BYTE};
				endcase
			OP_PROTECT:
				case (i)
					4'd0: s = {K_CMD, CMD_PROG};
					4'd1, 4'd2, 4'd3, 4'd4: s = {K_ADR, ZERO_BYTE};
					4'd5: s = {K_WR, ZERO_BYTE};
					4'd6: s = {K_CMD, CMD_PROG_GO};
					4'd7: s = {K_WAIT, ZERO_BYTE};
					4'd8: s = {K_CMD, CMD_STATUS};
					4'd9: s = {K_RD, ZERO_BYTE};
					default: s = {K_END, ZERO_BYTE};
				endcase
			OP_PROGRAM:
				case (i)
					4'd0: s = {K_CMD, CMD_PROG};
					4'd1: s = {K_ADR, c[7:0]};
					4'd2: s = {K_ADR, c[15:8]};
					4'd3: s = {K_ADR, r[7:0]};
					4'd4: s = {K_ADR, r[15:8]};
					4'd5: s = {K_WR, wd};
					4'd6: s = {K_CMD, CMD_PROG_GO};
					4'd7: s = {K_WAIT, ZERO_BYTE};
					4'd8: s = {K_CMD, CMD_STATUS};
					4'd9: s = {K_RD, ZERO_BYTE};
					default: s = {K_END, ZERO_BYTE};
				endcase
			OP_READ:
				case (i)
					4'd0: s = {K_CMD, CMD_READ};
					4'd1: s = {K_ADR, c[7:0]};
					4'd2: s = {K_ADR, c[15:8]};
					4'd3: s = {K_ADR, r[7:0]};
					4'd4: s = {K_ADR, r[15:8]};
					4'd5: s = {K_ADR, ZERO_BYTE};
					4'd6: s = {K_CMD, CMD_READ_GO};
					4'd7: s = {K_WAIT, ZERO_BYTE};
					4'd8: s = {K_CMD, CMD_STATUS};
					4'd9: s = {K_RD, ZERO_BYTE};
					4'd10: s = {K_CMD, CMD_READ};
					default: s = {K_END, ZERO_BYTE};
				endcase
			OP_COLOUT:
				case (i)
					4'd0: s = {K_CMD, CMD_COL_OUT};
					4'd1: s = {K_ADR, c[7:0]};
					4'd2: s = {K_ADR, c[15:8]};
					4'd3: s = {K_CMD, CMD_COL_OUT_GO};
					default: s = {K_END, ZERO_BYTE};
				endcase
			OP_RDBYTE:
				s = (i == 4'd0) ? {K_RD, ZERO_BYTE} : {K_END, ZERO_BYTE};
			OP_STATUS:
				case (i)
					4'd0: s = {K_CMD, CMD_STATUS};
					4'd1: s = {K_RD, ZERO_BYTE};
					default: s = {K_END, ZERO_BYTE};
				endcase
			default: s = {K_END, ZERO_BYTE};
		endcase
		return s;
	endfunction

	assign step    = stepOf(op, stepIdx, col, row, p1, wdata);
	assign cycByte = step[7:0];

	// ------------------------------------------------------------
	// Pin cycle engine
	// ------------------------------------------------------------
	ohc_tick_gen u_tick (
		.ref_clk (ref_clk),
		.arst_n  (arst_n),
		.tick    (tick)
	);

	ohc_pin_cycle u_cycle (
		.ref_clk     (ref_clk),
		.arst_n      (arst_n),
		.tick        (tick),
		.start       (cycStart),
		.kind        (step[10:8]),
		.wbyte       (cycByte),
		.ioIn        (ioIn),
		.cle         (cle),
		.ale         (ale),
		.weN         (weN),
		.readStrobeN (readStrobeN),
		.ioOut       (ioOut),
		.ioOe        (ioOe),
		.spare       (unusedSpare),
		.rbyte       (dataByteWire),
		.done        (cycDone)
	);

	// ------------------------------------------------------------
	// Request checks
	// ------------------------------------------------------------
	// Parity bytes live at 8..F of each 16-byte spare group past 2048
	assign parityCol = col[11] && (col[10:6] == 5'd0)
		&& (col[3:0] >= PARITY_LO);
	assign samePage  = (row == lastProgRow);
	assign otpPageOk = (row >= OTP_PAGE_LO) && (row <= OTP_PAGE_HI);

	assign apbWrite  = psel && penable && pready && pwrite;
	assign ctrlWrite = apbWrite && (paddr == REG_CTRL);

	always_comb
	begin
		refuseNow = 1'b0;
		unique case (ohc_op_type'(pwdata[CTRL_OP_LSB +: 4]))
			OP_FEATURE: refuseNow = !(pwdata[CTRL_P1_LSB +: 8] == P1_NORMAL
				|| pwdata[CTRL_P1_LSB +: 8] == P1_OTP_OPER
				|| pwdata[CTRL_P1_LSB +: 8] == P1_OTP_PROTECT);
			OP_PROTECT: refuseNow = (mode != MODE_PROTECT);
			OP_PROGRAM: refuseNow = eccOn && (parityCol
				|| (samePage && partials >= 3'(MAX_PARTIALS)));
			OP_READ:    refuseNow = (mode == MODE_OTP) && !otpPageOk;
			OP_COLOUT, OP_RDBYTE, OP_STATUS: refuseNow = 1'b0;
			default:    refuseNow = 1'b1;
		endcase
	end

	// A new order is taken only while idle, so every command, read-status
	// 70h included, waits for the die to be ready
	assign accept = ctrlWrite && (state == S_IDLE) && !refuseNow;

	// ------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			state       <= S_IDLE;
			stepIdx     <= 4'd0;
			settle      <= 8'h00;
			cycStart    <= 1'b0;
			chipEnableN <= 1'b1;
		end
		else
		begin
			cycStart <= 1'b0;
			unique case (state)
				S_IDLE:
					if (accept)
					begin
						state       <= S_ISSUE;
						stepIdx     <= 4'd0;
						chipEnableN <= 1'b0;
					end
				S_ISSUE:
					unique case (ohc_kind_type'(step[10:8]))
						K_END:
						begin
							state       <= S_IDLE;
							chipEnableN <= 1'b1;
						end
						K_WAIT:
						begin
							state  <= S_SETTLE;
							settle <= 8'h00;
						end
						K_CMD, K_ADR, K_WR, K_RD:
						begin
							state    <= S_CYCLE;
							cycStart <= 1'b1;
						end
						default: state <= S_IDLE;
					endcase
				S_CYCLE:
					if (cycDone)
					begin
						state   <= S_ISSUE;
						stepIdx <= stepIdx + 4'd1;
					end
				S_SETTLE:
				begin
					// Busy may not fall at once; hold off the ready test
					settle <= settle + 8'h01;
					if (settle == SETTLE_LAST)
						state <= S_BUSY;
				end
				S_BUSY:
					if (readyBusyN)
					begin
						state   <= S_ISSUE;
						stepIdx <= stepIdx + 4'd1;
					end
				default: state <= S_IDLE;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Order latches
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			op    <= OP_NONE;
			p1    <= 8'h00;
			col   <= 16'h0000;
			row   <= 16'h0000;
			wdata <= 8'h00;
		end
		else
		begin
			if (accept)
			begin
				op <= ohc_op_type'(pwdata[CTRL_OP_LSB +: 4]);
				p1 <= pwdata[CTRL_P1_LSB +: 8];
			end
			if (apbWrite && paddr == REG_ADDR && state == S_IDLE)
			begin
				col <= pwdata[15:0];
				row <= pwdata[31:16];
			end
			if (apbWrite && paddr == REG_DATA && state == S_IDLE)
				wdata <= pwdata[7:0];
		end
	end

	// ------------------------------------------------------------
	// Results and host-side bookkeeping
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			dataByte     <= 8'h00;
			statusByte   <= 8'h00;
			opFail       <= 1'b0;
			protectedOtp <= 1'b0;
			badMark      <= 1'b0;
			curCol       <= 16'h0000;
			mode         <= MODE_NORMAL;
		end
		else
		begin
			if (accept && (op == OP_NONE || 1'b1))
			begin
				if (pwdata[CTRL_OP_LSB +: 4] == OP_READ
					|| pwdata[CTRL_OP_LSB +: 4] == OP_COLOUT)
					curCol <= col;
			end
			if (state == S_CYCLE && cycDone && step[10:8] == K_RD)
			begin
				if (op == OP_RDBYTE)
				begin
					dataByte <= dataByteWire;
					curCol   <= curCol + 16'h0001;
					if (curCol == SPARE_COL)
						badMark <= (dataByteWire == BAD_MARK);
				end
				else
				begin
					statusByte <= dataByteWire;
					opFail     <= dataByteWire[STS_FAIL_BIT];
					if (op == OP_PROTECT && !dataByteWire[STS_FAIL_BIT])
						protectedOtp <= 1'b1;
				end
			end
			if (state == S_ISSUE && step[10:8] == K_END && op == OP_FEATURE)
			begin
				unique case (p1)
					P1_OTP_OPER:    mode <= MODE_OTP;
					P1_OTP_PROTECT: mode <= MODE_PROTECT;
					default:        mode <= MODE_NORMAL;
				endcase
			end
		end
	end

	// Partial programs per page, counted whether or not internal ECC is on
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			partials    <= 3'd0;
			lastProgRow <= 16'hffff;
		end
		else if (accept && pwdata[CTRL_OP_LSB +: 4] == OP_PROGRAM)
		begin
			lastProgRow <= row;
			partials    <= samePage ? partials + 3'd1 : 3'd1;
		end
	end

	// Refused orders stay flagged until the next accepted order
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
			refused <= 1'b0;
		else if (ctrlWrite)
			refused <= !accept;
	end

	// ------------------------------------------------------------
	// Register file
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			eccOn         <= CFG_RESET[CFG_ECC_BIT];
			block0LowWear <= CFG_RESET[CFG_WEAR_BIT];
		end
		else if (apbWrite && paddr == REG_CONFIG)
		begin
			eccOn         <= pwdata[CFG_ECC_BIT];
			block0LowWear <= pwdata[CFG_WEAR_BIT];
		end
	end

	// Correction software must still apply per 528-byte unit
	always_comb
	begin
		if (eccOn)
			minEccBits = ECC_BITS_INT;
		else if (block0LowWear && row[15:6] == 10'd0)
			minEccBits = ECC_BITS_BLK0;
		else
			minEccBits = ECC_BITS_STD;
	end

	always_comb
	begin
		statusWord = 32'h0000_0000;
		statusWord[ST_BUSY_BIT]           = (state != S_IDLE);
		statusWord[ST_FAIL_BIT]           = opFail;
		statusWord[ST_PROT_BIT]           = protectedOtp;
		statusWord[ST_REFUSE_BIT]         = refused;
		statusWord[ST_BAD_BIT]            = badMark;
		statusWord[ST_RB_BIT]             = readyBusyN;
		statusWord[ST_MODE_LSB +: 2]      = mode;
		statusWord[ST_BYTE_LSB +: 8]      = statusByte;
		statusWord[ST_PCNT_LSB +: 3]      = partials;
		statusWord[ST_ECC_LSB +: 4]       = minEccBits;
	end

	// One wait state: pready rises in the second access cycle
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end
		else
		begin
			pready  <= psel && penable && !pready;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
			if (psel && penable && !pready)
			begin
				unique case (paddr)
					REG_CTRL:   prdata <= {16'h0000, p1, 4'h0, op};
					REG_ADDR:   prdata <= {row, col};
					REG_DATA:   prdata <= {24'h000000, dataByte};
					REG_STATUS: prdata <= statusWord;
					REG_CONFIG: prdata <= {30'h0, block0LowWear, eccOn};
					default:    pslverr <= 1'b1;
				endcase
			end
		end
	end

	// The die is write-protected from this side only while arst_n is low
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
			writeProtectN <= 1'b0;
		else
			writeProtectN <= 1'b1;
	end

endmodule

//--- hdl/ohc_host_fix.sv
// Spare design file; holds no logic.

//--- bench/ohc_host_chk.sv
// Pin and APB checker for ohc_host.
// Sees only the host ports; bound from the bench top.
`timescale 1ns/1ps
module ohc_host_chk
(
	input wire logic        ref_clk,
	input wire logic        arst_n,
	input wire logic [7:0]  paddr,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        chipEnableN,
	input wire logic        cle,
	input wire logic        ale,
	input wire logic        weN,
	input wire logic        readStrobeN,
	input wire logic        ioOe
);
	// ---------------------------
	// Properties
	// ---------------------------
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!arst_n);
	property p_pulse; pready |=> !pready; endproperty
	property p_wait; psel && !penable |-> ##2 pready; endproperty
	property p_err;
		pslverr |-> pready && !(paddr inside {8'h00,8'h04,8'h08,8'h0c,8'h10});
	endproperty
	property p_zero; !pready |-> prdata == 32'h0; endproperty
	property p_strb; !(!weN && !readStrobeN); endproperty
	property p_latch; !(cle && ale); endproperty
	property p_turn; $fell(readStrobeN) |-> !ioOe && !cle; endproperty
	property p_ce; !weN || !readStrobeN |-> !chipEnableN; endproperty
	a_pulse: assert property (p_pulse) else $error("pready too long");
	a_wait: assert property (p_wait) else $error("pready late");
	a_err: assert property (p_err) else $error("bad pslverr");
	a_zero: assert property (p_zero) else $error("prdata not zero");
	a_strb: assert property (p_strb) else $error("both strobes low");
	a_latch: assert property (p_latch) else $error("cle with ale");
	a_turn: assert property (p_turn) else $error("bus not turned");
	a_ce: assert property (p_ce) else $error("strobe unselected");
	c_err: cover property (pslverr);
	c_rd: cover property ($fell(readStrobeN));
	c_cmd: cover property (cle && ioOe);
endmodule

//--- bench/ohc_nand_model.sv
// Behavioural NAND die: OTP modes, protection, bad mark, status byte.
// Assumes host pins move on ref_clk edges; busy times are shortened.
`timescale 1ns/1ps
module ohc_nand_model
(
	input wire logic       ref_clk,
	input wire logic       ceN,
	input wire logic       cle,
	input wire logic       ale,
	input wire logic       weN,
	input wire logic       reN,
	input wire logic [7:0] din,
	output logic [7:0]     dout,
	output logic           rbN
);
	logic [7:0] cmd = 0, last = 0;
	logic [15:0] col = 0, row = 0;
	logic [2:0] na = 0;
	logic weP = 1, reP = 1, prot = 0, fail = 0, sOut = 0;
	logic [1:0] mode = 0;
	int bsy = 0;
	assign rbN = (bsy == 0);
	// Released bus shows the inverse of the last byte, not a held value
	assign dout = reN ? ~last : sOut ? {2'h3, rbN, 4'h0, fail}
		: col == 16'd2048 ? {8{row != 16'h0040}}
		: col[7:0] ^ row[7:0];
	// Latch on rising strobes; protection never clears
	always @(posedge ref_clk)
	begin
		weP <= weN;
		reP <= reN;
		if (bsy > 0) bsy <= bsy - 1;
		if (!reN && reP) last <= dout;
		if (reN && !reP && !sOut) col <= col + 16'h1;
		if (weN && !weP && !ceN)
		begin
			if (cle)
			begin
				cmd <= din;
				na <= 3'h0;
				sOut <= din == 8'h70;
				if (din == 8'h30) bsy <= 50;
				if (din == 8'h10 && prot)
				begin
					bsy <= 5;
					fail <= 1'h1;
				end
				else if (din == 8'h10)
				begin
					bsy <= 60;
					fail <= 1'h0;
					prot <= mode == 2'h3;
				end
			end
			else if (ale)
			begin
				na <= na + 3'h1;
				case (na)
				3'h0: col[7:0] <= din;
				3'h1: col[15:8] <= din;
				3'h2: row[7:0] <= din;
				3'h3: row[15:8] <= din;
				default: ;
				endcase
			end
			else if (cmd == 8'hef && na == 3'h1)
			begin
				mode <= din[1:0];
				na <= 3'h2;
			end
		end
	end
endmodule

//--- bench/test_ohc_host.sv
// Self-checking bench: ohc_host driving the behavioural NAND die.
// Assumes the ohc_pkg register map and an APB master in this module.
`timescale 1ns/1ps
module test_ohc_host import ohc_pkg::*;;
	logic ref_clk = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0;
	logic [7:0] paddr = 0, ioOut, dout;
	logic [31:0] pwdata = 0, prdata, rd;
	logic pready, pslverr, chipEnableN, cle, ale, weN, readStrobeN, ioOe;
	logic rbN, er, wpN;
	int errors = 0, checks = 0;
	ohc_host u_ohc_host (.ref_clk, .arst_n, .paddr, .psel, .penable,
		.pwrite, .pwdata, .prdata, .pready, .pslverr, .chipEnableN, .cle,
		.ale, .weN, .readStrobeN, .writeProtectN(wpN), .ioOut, .ioOe,
		.ioIn(dout), .readyBusyN(rbN));
	ohc_nand_model u_ohc_nand_model (.ref_clk, .ceN(chipEnableN), .cle,
		.ale, .weN, .reN(readStrobeN), .din(ioOut), .dout, .rbN);
	initial forever #5 ref_clk = ~ref_clk;
	task automatic close_out;
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp)
		begin
			errors++;
			$display("CHECK FAILED %0t got %h want %h", $time, got, exp);
		end
	endtask
	// APB transfer; holds the request until pready is sampled high
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge ref_clk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'h1;
		do @(posedge ref_clk); while (pready !== 1'h1);
		rd = prdata;
		er = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	// Start an operation, then poll STATUS until busy clears
	task automatic op(input ohc_op_type o, input logic [7:0] p);
		apb(1'h1, REG_CTRL, {16'h0, p, 4'h0, o});
		do apb(1'h0, REG_STATUS, 32'h0); while (rd[ST_BUSY_BIT] !== 1'h0);
	endtask
	task automatic rd_byte(input logic [31:0] a, input logic [7:0] e);
		apb(1'h1, REG_ADDR, a);
		op(OP_READ, 8'h0);
		op(OP_RDBYTE, 8'h0);
		apb(1'h0, REG_DATA, 32'h0);
		chk(rd[7:0], e);
	endtask
	task automatic t_regs;
		apb(1'h0, REG_CONFIG, 32'h0);
		chk(rd, CFG_RESET);
		chk(wpN, 1'h1);
		apb(1'h0, 8'h14, 32'h0);
		chk(er, 1'h1);
		chk(rd, 32'h0);
		op(OP_FEATURE, 8'h02);
		chk(rd[ST_REFUSE_BIT], 1'h1);
		chk(rd[23:20], ECC_BITS_STD);
		apb(1'h1, REG_CONFIG, 32'h2);
		apb(1'h0, REG_STATUS, 32'h0);
		chk(rd[23:20], ECC_BITS_BLK0);
		$display("regs done");
	endtask
	task automatic t_otp;
		op(OP_FEATURE, P1_OTP_OPER);
		chk(rd[7:6], MODE_OTP);
		rd_byte({16'h0002, 16'h0005}, 8'h07);
		op(OP_RDBYTE, 8'h0);
		chk(rd[15:8], 8'he0);
		apb(1'h0, REG_DATA, 32'h0);
		chk(rd[7:0], 8'h04);
		apb(1'h1, REG_ADDR, {16'h0002, 16'h0010});
		op(OP_COLOUT, 8'h0);
		op(OP_RDBYTE, 8'h0);
		apb(1'h0, REG_DATA, 32'h0);
		chk(rd[7:0], 8'h12);
		$display("otp read done");
	endtask
	task automatic t_prot;
		op(OP_FEATURE, P1_OTP_PROTECT);
		op(OP_PROTECT, 8'h0);
		chk(rd[ST_PROT_BIT], 1'h1);
		op(OP_FEATURE, P1_OTP_OPER);
		apb(1'h1, REG_ADDR, 32'h0003_0000);
		op(OP_PROGRAM, 8'h0);
		chk(rd[ST_FAIL_BIT] | rd[ST_REFUSE_BIT], 1'h1);
		op(OP_STATUS, 8'h0);
		chk(rd[15:8], 8'he1);
		rd_byte(32'h001f_0000, 8'h1f);
		op(OP_FEATURE, P1_NORMAL);
		chk(rd[7:6], MODE_NORMAL);
		rd_byte({16'h0040, SPARE_COL}, BAD_MARK);
		apb(1'h0, REG_STATUS, 32'h0);
		chk(rd[ST_BAD_BIT], 1'h1);
		$display("protect done");
	endtask
	// Parity columns must be refused once internal ECC is on
	task automatic t_ecc;
		apb(1'h1, REG_CONFIG, 32'h1);
		apb(1'h0, REG_STATUS, 32'h0);
		chk(rd[23:20], ECC_BITS_INT);
		apb(1'h1, REG_ADDR, {16'h0040, 16'h0808});
		op(OP_PROGRAM, 8'h0);
		chk(rd[ST_REFUSE_BIT], 1'h1);
		$display("ecc done");
	endtask
	initial
	begin
		repeat (2) @(posedge ref_clk);
		arst_n <= 1'h1;
		t_regs();
		t_otp();
		t_prot();
		t_ecc();
		close_out();
	end
	initial
	begin
		repeat (60000) @(posedge ref_clk);
		errors++;
		close_out();
	end
endmodule
bind ohc_host ohc_host_chk u_ohc_host_chk (.ref_clk, .arst_n, .paddr,
	.psel, .penable, .prdata, .pready, .pslverr, .chipEnableN, .cle, .ale,
	.weN, .readStrobeN, .ioOe);
